// [src/orp_pkg.sv]
// Constants and carrier types for the one-time-programmable ROM programmer
// How it works
// [RL1] Program pulse lasts 95 to 105 us
// [RL2] Sequence starts at the first address
// [RL3] Raise both supplies before any pulse
// [RL4] First pass: one pulse, no read
// [RL5] Retry pulses, verify after each, ten max
// [RL6] Still failing after ten: stop, report fail
// [RL7] Good byte: advance until all checked
// [RL8] Lower supplies, read back all, report
// [RL9] Address bit zero selects maker/device code
// [RL10] Identification needs raised voltage on pin
// [RL11] Verify read: strobes low, sample, compare
package orp_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_PULSE_NS = 100000;
    localparam int T_SETUP_NS = 2000;
    localparam int T_DATA_VALID_NS = 1000;
    // Least times round up
    localparam int PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (T_DATA_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    localparam int RETRY_MAX = 10;
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 16'h0000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PWR = 4'h1,
        ST_SET = 4'h2,
        ST_PULSE = 4'h3,
        ST_HOLD = 4'h4,
        ST_VREC = 4'h5,
        ST_VREAD = 4'h6,
        ST_FSET = 4'h7,
        ST_FREAD = 4'h8,
        ST_ID = 4'h9,
        ST_IDRD = 4'ha
    } orp_state_t;

    // Pin bundle driven toward the ROM
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
        logic data_oe;
        logic ce_n;
        logic oe_n;
        logic vpp_en;
        logic vcc_hi;
        logic id_hv;
    } orp_pins_t;

    localparam orp_pins_t PINS_RESET = '{addr: 16'h0000, data: 8'h00, data_oe: 1'b0,
        ce_n: 1'b1, oe_n: 1'b1, vpp_en: 1'b0, vcc_hi: 1'b0, id_hv: 1'b0};

endpackage : orp_pkg

// [src/orp_programmer.sv]
// Programmer that writes, verifies and identifies a 64K x 8 OTP ROM
`timescale 1ns/1ps
module orp_programmer import orp_pkg::*; #(
    parameter int PULSE_CYCLES = PULSE_CYC,
    // Top of the swept array; lower it only to shorten a test run
    parameter logic [ADDR_W-1:0] LAST_ADDR = {ADDR_W{1'b1}}
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // User commands
    input wire logic start_i,
    input wire logic id_req_i,
    input wire logic id_sel_i,
    // Source image, byte for src_addr_o
    output logic [ADDR_W-1:0] src_addr_o,
    input wire logic [7:0] src_data_i,
    // Status
    output logic busy_o,
    output logic done_o,
    output logic pass_o,
    output logic fail_o,
    output logic id_valid_o,
    output logic [7:0] id_code_o,
    // ROM pins
    output orp_pins_t pins_o,
    input wire logic [7:0] rom_data_i
);

    // ----------------------------------------------------------------
    // Input sync and wait counter
    // ----------------------------------------------------------------
    logic [7:0] rom_s1_ff;
    logic [7:0] rom_s2_ff;
    orp_state_t state_ff;
    orp_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [3:0] retry_ff;
    logic second_pass_ff;
    logic mism_ff;
    logic id_sel_ff;
    logic wait_done;
    logic last_addr;
    logic match;

    function automatic logic [CNT_W-1:0] wait_load(input int cycles);
        wait_load = CNT_W'(cycles - 1);
    endfunction : wait_load

    always_ff @(posedge sys_clk_i) begin
        rom_s1_ff <= rom_data_i;
        rom_s2_ff <= rom_s1_ff;
    end

    assign wait_done = (cnt_ff == '0);
    assign last_addr = (pins_o.addr == LAST_ADDR);
    assign match = (rom_s2_ff == src_data_i); // RL11

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = wait_done ? cnt_ff : cnt_ff - 1'b1;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_i) begin
                    nxt_state = ST_PWR;
                    nxt_cnt = wait_load(SETUP_CYC);
                end else if (id_req_i) begin
                    nxt_state = ST_ID;
                    nxt_cnt = wait_load(SETUP_CYC);
                end
            end
            ST_PWR: if (wait_done) begin
                nxt_state = ST_SET; // RL3
                nxt_cnt = wait_load(SETUP_CYC);
            end
            ST_SET: if (wait_done) begin
                nxt_state = ST_PULSE;
                nxt_cnt = wait_load(PULSE_CYCLES); // RL1
            end
            ST_PULSE: if (wait_done) begin
                nxt_state = ST_HOLD;
                nxt_cnt = wait_load(SETUP_CYC);
            end
            ST_HOLD: if (wait_done) begin
                // No read in the first pass
                nxt_state = (!second_pass_ff && !last_addr) ? ST_SET : ST_VREC; // RL4
                nxt_cnt = wait_load(SETUP_CYC);
            end
            ST_VREC: if (wait_done) begin
                nxt_state = ST_VREAD;
                nxt_cnt = wait_load(READ_CYC);
            end
            ST_VREAD: if (wait_done) begin
                nxt_cnt = wait_load(SETUP_CYC);
                if (match) begin
                    nxt_state = last_addr ? ST_FSET : ST_VREC; // RL7
                end else if (retry_ff == 4'(RETRY_MAX)) begin
                    nxt_state = ST_IDLE; // RL6
                end else begin
                    nxt_state = ST_SET; // RL5
                end
            end
            ST_FSET: if (wait_done) begin
                nxt_state = ST_FREAD;
                nxt_cnt = wait_load(READ_CYC);
            end
            ST_FREAD: if (wait_done) begin
                nxt_state = last_addr ? ST_IDLE : ST_FREAD; // RL8
                nxt_cnt = wait_load(READ_CYC);
            end
            ST_ID: if (wait_done) begin
                nxt_state = ST_IDRD;
                nxt_cnt = wait_load(READ_CYC);
            end
            ST_IDRD: if (wait_done) begin
                nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // ----------------------------------------------------------------
    // Address, pass and retry tracking
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pins_o.addr <= ADDR_FIRST;
            second_pass_ff <= 1'b0;
            retry_ff <= '0;
            id_sel_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && start_i) begin
            pins_o.addr <= ADDR_FIRST; // RL2
            second_pass_ff <= 1'b0;
            retry_ff <= '0;
        end else if (state_ff == ST_IDLE && id_req_i) begin
            id_sel_ff <= id_sel_i;
            pins_o.addr <= {{(ADDR_W-1){1'b0}}, id_sel_i}; // RL9
        end else if (wait_done) begin
            if (state_ff == ST_HOLD && !second_pass_ff) begin
                pins_o.addr <= last_addr ? ADDR_FIRST : pins_o.addr + 1'b1; // RL4
                second_pass_ff <= last_addr;
            end else if (state_ff == ST_VREAD && match) begin
                pins_o.addr <= last_addr ? ADDR_FIRST : pins_o.addr + 1'b1; // RL7
                retry_ff <= '0;
            end else if (state_ff == ST_VREAD && retry_ff != 4'(RETRY_MAX)) begin
                retry_ff <= retry_ff + 1'b1; // RL5
            end else if (state_ff == ST_FREAD && !last_addr) begin
                pins_o.addr <= pins_o.addr + 1'b1; // RL8
            end
        end
    end

    assign src_addr_o = pins_o.addr;

    // ----------------------------------------------------------------
    // Pin levels, all but data decoded from the next state so they move with it
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pins_o.data <= PINS_RESET.data;
            pins_o.data_oe <= PINS_RESET.data_oe;
            pins_o.ce_n <= PINS_RESET.ce_n;
            pins_o.oe_n <= PINS_RESET.oe_n;
            pins_o.vpp_en <= PINS_RESET.vpp_en;
            pins_o.vcc_hi <= PINS_RESET.vcc_hi;
            pins_o.id_hv <= PINS_RESET.id_hv;
        end else begin
            pins_o.data <= src_data_i;
            pins_o.data_oe <= nxt_state inside {ST_SET, ST_PULSE, ST_HOLD};
            pins_o.ce_n <= !(nxt_state inside {ST_PULSE, ST_VREAD, ST_FREAD, ST_IDRD});
            pins_o.oe_n <= !(nxt_state inside {ST_VREAD, ST_FREAD, ST_IDRD}); // RL11
            pins_o.vpp_en <= nxt_state inside {ST_PWR, ST_SET, ST_PULSE, ST_HOLD}; // RL3
            pins_o.vcc_hi <= nxt_state inside {ST_PWR, ST_SET, ST_PULSE, ST_HOLD,
                ST_VREC, ST_VREAD}; // RL8
            pins_o.id_hv <= nxt_state inside {ST_ID, ST_IDRD}; // RL10
        end
    end

    // ----------------------------------------------------------------
    // Results
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            pass_o <= 1'b0;
            fail_o <= 1'b0;
            mism_ff <= 1'b0;
            id_valid_o <= 1'b0;
            id_code_o <= 8'h00;
        end else begin
            busy_o <= (nxt_state != ST_IDLE);
            done_o <= 1'b0;
            id_valid_o <= 1'b0;
            if (state_ff == ST_IDLE && start_i) begin
                pass_o <= 1'b0;
                fail_o <= 1'b0;
                mism_ff <= 1'b0;
            end
            if (state_ff == ST_VREAD && wait_done && !match && retry_ff == 4'(RETRY_MAX)) begin
                done_o <= 1'b1;
                fail_o <= 1'b1; // RL6
            end
            if (state_ff == ST_FREAD && wait_done) begin
                // Keep reading after a miss so the whole image is swept
                mism_ff <= mism_ff | !match;
                if (last_addr) begin
                    done_o <= 1'b1;
                    pass_o <= !(mism_ff | !match); // RL8
                    fail_o <= mism_ff | !match;
                end
            end
            if (state_ff == ST_IDRD && wait_done) begin
                id_valid_o <= 1'b1;
                id_code_o <= rom_s2_ff; // RL9
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] low_len_ff;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || pins_o.ce_n) begin
            low_len_ff <= '0;
        end else begin
            low_len_ff <= low_len_ff + 1'b1;
        end
    end

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    pulse_width_a: assert property ($rose(pins_o.ce_n) && $past(pins_o.vpp_en)
        |-> $past(low_len_ff) == CNT_W'(PULSE_CYCLES - 1)) // RL1
        else $error("program pulse width wrong");
    start_addr_a: assert property ($rose(busy_o) && pins_o.vpp_en
        |-> pins_o.addr == ADDR_FIRST) // RL2
        else $error("sequence did not start at first address");
    supply_first_a: assert property ($fell(pins_o.ce_n) && pins_o.data_oe
        |-> pins_o.vpp_en && pins_o.vcc_hi && $past(pins_o.vpp_en, 2)) // RL3
        else $error("pulse without raised supplies");
    first_noread_a: assert property (!second_pass_ff && pins_o.vpp_en
        |-> pins_o.oe_n) // RL4
        else $error("read during first pass");
    retry_cap_a: assert property (retry_ff <= 4'(RETRY_MAX)) // RL5
        else $error("too many retry pulses");
    fail_stop_a: assert property ($rose(fail_o) && !$past(state_ff == ST_FREAD)
        |-> state_ff == ST_IDLE && !pins_o.vpp_en && $past(retry_ff) == 4'(RETRY_MAX)) // RL6
        else $error("fail without stopping");
    advance_a: assert property (state_ff == ST_VREAD && wait_done && match && !last_addr
        |=> pins_o.addr == $past(pins_o.addr) + 1'b1 && retry_ff == '0) // RL7
        else $error("address did not advance");
    final_read_a: assert property (state_ff == ST_FREAD
        |-> !pins_o.vcc_hi && !pins_o.vpp_en && !pins_o.ce_n) // RL8
        else $error("final read at programming supply");
    verify_read_a: assert property (!pins_o.oe_n
        |-> !pins_o.ce_n && !pins_o.data_oe && !pins_o.vpp_en) // RL11
        else $error("bad strobe levels while reading");
    id_read_a: assert property (state_ff == ST_IDRD
        |-> pins_o.id_hv && pins_o.addr[0] == id_sel_ff) // RL10
        else $error("identification read without raised pin");

    pass_seen_c: cover property (done_o && pass_o);
    fail_seen_c: cover property (done_o && fail_o);
    retry_seen_c: cover property (state_ff == ST_PULSE && retry_ff != '0);
    id_seen_c: cover property (id_valid_o && id_sel_ff);

endmodule : orp_programmer

// [tb/orp_rom_model.sv]
// Behavioural model of the 64K x 8 one-time-programmable ROM
`timescale 1ns/1ps
module orp_rom_model import orp_pkg::*; #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEVICE_CODE = 8'ha7 // Arbitrary value
) (
    // Pins from the programmer
    input wire orp_pins_t pins_i,
    // Outputs toward the programmer
    output logic [7:0] rom_data_o
);
    // ----------------------------------------------------------------
    // Array
    // ----------------------------------------------------------------
    // Erased cells read as ones; a pulse only clears bits
    logic [7:0] mem [logic [15:0]];
    logic [7:0] last_q = 8'h00;

    function automatic logic [7:0] rd(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction : rd

    // Cell changes only with both supplies raised
    always @(posedge pins_i.ce_n) begin
        if (pins_i.vpp_en && pins_i.vcc_hi && pins_i.data_oe) begin
            mem[pins_i.addr] = rd(pins_i.addr) & pins_i.data;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always @(pins_i) begin
        if (!pins_i.ce_n && !pins_i.oe_n && !pins_i.vpp_en) begin
            rom_data_o = pins_i.id_hv ? (pins_i.addr[0] ? DEVICE_CODE : MAKER_CODE)
                : rd(pins_i.addr);
            last_q = rom_data_o;
        end else begin
            // Floating, no pull: show the inverse so stale data cannot pass
            rom_data_o = ~last_q;
        end
    end
endmodule : orp_rom_model

// [tb/orp_programmer_tb.sv]
// Self-checking bench for the OTP ROM programmer
`timescale 1ns/1ps
module orp_programmer_tb import orp_pkg::*; ;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    localparam int PULSE = 20;
    localparam int WAIT_MAX = 15000;
    // Short array so full runs end inside the watchdog span
    localparam logic [ADDR_W-1:0] LAST_A = 16'h0003;
    localparam int ADDRS = int'(LAST_A) + 1;
    localparam logic [7:0] ID_MAKER = 8'h5a; // Arbitrary value
    localparam logic [7:0] ID_DEVICE = 8'ha7; // Arbitrary value
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic start_i = 1'b0;
    logic id_req_i = 1'b0;
    logic id_sel_i = 1'b0;
    logic [7:0] src_data_i = 8'h00;
    logic [ADDR_W-1:0] src_addr_o;
    logic busy_o, done_o, pass_o, fail_o, id_valid_o;
    logic [7:0] id_code_o;
    logic [7:0] rom_data_i;
    orp_pins_t pins_o;
    int errors = 0;
    int total_checks = 0;
    logic [7:0] img_flip = 8'h00;

    always #4 sys_clk_i = ~sys_clk_i;

    // Source image is a simple function of the address, one cycle late
    function automatic logic [7:0] img(input logic [15:0] a);
        return a[7:0] ^ 8'h3c;
    endfunction : img

    always @(posedge sys_clk_i) begin
        src_data_i <= img(src_addr_o) ^ img_flip;
    end

    orp_programmer #(.PULSE_CYCLES(PULSE), .LAST_ADDR(LAST_A)) orp_programmer_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i), .id_req_i(id_req_i),
        .id_sel_i(id_sel_i), .src_addr_o(src_addr_o), .src_data_i(src_data_i),
        .busy_o(busy_o), .done_o(done_o), .pass_o(pass_o), .fail_o(fail_o),
        .id_valid_o(id_valid_o), .id_code_o(id_code_o), .pins_o(pins_o),
        .rom_data_i(rom_data_i));

    orp_rom_model #(.MAKER_CODE(ID_MAKER), .DEVICE_CODE(ID_DEVICE)) orp_rom_model_inst (
        .pins_i(pins_o), .rom_data_o(rom_data_i));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic do_reset(input int cycles);
        rst_i <= 1'b1;
        start_i <= 1'b0;
        id_req_i <= 1'b0;
        repeat (cycles) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        check("idle pins", {2'b00, pins_o}, {2'b00, PINS_RESET});
        check("idle busy", {31'h0, busy_o}, 32'h0);
    endtask : do_reset

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_id(input logic sel, input logic [7:0] code);
        int n;
        logic seen;
        @(posedge sys_clk_i);
        id_req_i <= 1'b1;
        id_sel_i <= sel;
        @(posedge sys_clk_i);
        id_req_i <= 1'b0;
        n = 0;
        seen = 1'b0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (pins_o.id_hv === 1'b1 && pins_o.ce_n === 1'b0 && pins_o.addr[0] === sel) begin
                seen = 1'b1;
            end
        end while (id_valid_o !== 1'b1 && n < WAIT_MAX);
        check("id raised read", {31'h0, seen}, 32'h1);
        check("id code", {24'h0, id_code_o}, {24'h0, code});
        check("id busy", {31'h0, busy_o}, 32'h0);
        @(posedge sys_clk_i);
        #1;
        check("id valid pulse", {31'h0, id_valid_o}, 32'h0);
        check("id pin low", {31'h0, pins_o.id_hv}, 32'h0);
    endtask : test_id

    // Start beats a simultaneous id request; id refused while busy
    task automatic test_program();
        int n, pulses, width;
        @(posedge sys_clk_i);
        start_i <= 1'b1;
        id_req_i <= 1'b1;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
        id_req_i <= 1'b0;
        n = 0;
        pulses = 0;
        width = 0;
        while (pulses < 3 && n < WAIT_MAX) begin
            @(posedge sys_clk_i);
            id_req_i <= (n == 300);
            #1;
            n++;
            if (n == 2) check("busy", {31'h0, busy_o}, 32'h1);
            if (pins_o.id_hv !== 1'b0 || id_valid_o !== 1'b0) begin
                check("id refused", 32'h1, 32'h0);
            end
            if (n > 1 && {pins_o.vpp_en, pins_o.vcc_hi} !== 2'b11) begin
                check("supplies raised", {30'h0, pins_o.vpp_en, pins_o.vcc_hi}, 32'h3);
            end
            if (pins_o.ce_n === 1'b0) begin
                width++;
                if (width == 1) begin
                    check("pulse addr", {16'h0, pins_o.addr}, 32'(pulses));
                    check("pulse data", {24'h0, pins_o.data}, {24'h0, img(pins_o.addr)});
                    check("data driven", {31'h0, pins_o.data_oe}, 32'h1);
                end
            end else if (width > 0) begin
                check("pulse width", 32'(width), 32'(PULSE));
                pulses++;
                width = 0;
            end
        end
        check("pulse count", 32'(pulses), 32'h3);
        for (int i = 0; i < 3; i++) begin
            check("cell", {24'h0, orp_rom_model_inst.rd(16'(i))}, {24'h0, img(16'(i))});
        end
        // Reset in mid-sequence must return every pin to idle
        @(posedge sys_clk_i);
        do_reset(2);
    endtask : test_program

    // Start a full run; split strobe-low cycles by supply state until done
    task automatic run_to_done(output int pulse_cyc, output int vfy_cyc, output int fin_cyc);
        int n;
        pulse_cyc = 0;
        vfy_cyc = 0;
        fin_cyc = 0;
        n = 0;
        @(posedge sys_clk_i);
        start_i <= 1'b1;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
            if (n == 1) check("status cleared", {30'h0, pass_o, fail_o}, 32'h0);
            if (pins_o.ce_n === 1'b0) begin
                if (pins_o.vpp_en === 1'b1) begin
                    pulse_cyc++;
                end else if (pins_o.vcc_hi === 1'b1) begin
                    vfy_cyc++;
                end else begin
                    fin_cyc++;
                end
            end
        end while (done_o !== 1'b1 && n < WAIT_MAX);
        check("done seen", {31'h0, done_o}, 32'h1);
        check("busy at done", {31'h0, busy_o}, 32'h0);
    endtask : run_to_done

    task automatic test_full_pass();
        int pulse_cyc, vfy_cyc, fin_cyc;
        run_to_done(pulse_cyc, vfy_cyc, fin_cyc);
        check("pass flags", {30'h0, pass_o, fail_o}, 32'h2);
        check("pulse cycles", 32'(pulse_cyc), 32'(ADDRS * PULSE));
        check("verify cycles", 32'(vfy_cyc), 32'(ADDRS * READ_CYC));
        check("readback cycles", 32'(fin_cyc), 32'(ADDRS * READ_CYC));
        @(posedge sys_clk_i);
        #1;
        check("done one cycle", {31'h0, done_o}, 32'h0);
        check("pass stands", {31'h0, pass_o}, 32'h1);
    endtask : test_full_pass

    // Asks for bit 0 where the cell already holds 0, so address 0 never verifies
    task automatic test_full_fail();
        int pulse_cyc, vfy_cyc, fin_cyc;
        img_flip = 8'h01;
        run_to_done(pulse_cyc, vfy_cyc, fin_cyc);
        img_flip = 8'h00;
        check("fail flags", {30'h0, pass_o, fail_o}, 32'h1);
        check("retry pulses", 32'(pulse_cyc), 32'((ADDRS + RETRY_MAX) * PULSE));
        check("retry reads", 32'(vfy_cyc), 32'((RETRY_MAX + 1) * READ_CYC));
        check("no readback", 32'(fin_cyc), 32'h0);
        check("halted supply", {30'h0, pins_o.vpp_en, pins_o.vcc_hi}, 32'h0);
        check("halted strobes", {30'h0, pins_o.ce_n, pins_o.oe_n}, 32'h3);
    endtask : test_full_fail

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        do_reset(20);
        test_id(1'b0, ID_MAKER);
        test_id(1'b1, ID_DEVICE);
        test_program();
        test_full_pass();
        test_full_fail();
        test_id(1'b1, ID_DEVICE);
        wrap_up();
    end

    // Run needs about 20000 cycles, mostly the retry run; this leaves margin
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        errors++;
        $display("ERROR watchdog expected completion seen timeout");
        wrap_up();
    end
endmodule : orp_programmer_tb
